// ===== hdl/flag_bank_pkg.sv
// Package of constants, types and helpers for interrupt request flag bank 0.
package flag_bank_pkg;

  // ----------------------------------------------------------------------
  // Bus geometry and register map
  // ----------------------------------------------------------------------
  localparam int              FLAG_W      = 32;
  localparam int              ADDR_W      = 5;
  localparam int              STRB_W      = 4;
  localparam int              NUM_EXTPIN  = 5;
  localparam logic [ADDR_W-1:0] OFF_FLAGS = 5'h00;
  localparam logic [ADDR_W-1:0] OFF_CLR   = 5'h04;
  localparam logic [ADDR_W-1:0] OFF_SET   = 5'h08;
  localparam logic [ADDR_W-1:0] OFF_INV   = 5'h0c;
  localparam logic [ADDR_W-1:0] OFF_POL   = 5'h10;
  localparam logic [FLAG_W-1:0] FLAG_RESET = 32'h00000000;
  localparam logic [NUM_EXTPIN-1:0] POL_RESET = 5'h00;
  localparam logic [1:0]      RESP_OKAY   = 2'h0;
  localparam logic [1:0]      RESP_DECERR = 2'h3;
  localparam logic [1:0]      SETTLE_CYCLES = 2'h3;

  // ----------------------------------------------------------------------
  // Flag positions
  // ----------------------------------------------------------------------
  localparam int BIT_TWI1_MASTER = 31;
  localparam int BIT_TWI1_SLAVE  = 30;
  localparam int BIT_TWI1_COLL   = 29;
  localparam int BIT_UART1_TX    = 28;
  localparam int BIT_UART1_RX    = 27;
  localparam int BIT_UART1_ERR   = 26;
  localparam int BIT_SYNC1_RX    = 25;
  localparam int BIT_SYNC1_TX    = 24;
  localparam int BIT_SYNC1_ERR   = 23;
  localparam int BIT_OUTCMP5     = 22;
  localparam int BIT_INCAP5      = 21;
  localparam int BIT_TIMER5      = 20;
  localparam int BIT_EXTPIN4     = 19;
  localparam int BIT_OUTCMP4     = 18;
  localparam int BIT_INCAP4      = 17;
  localparam int BIT_TIMER4      = 16;
  localparam int BIT_EXTPIN3     = 15;
  localparam int BIT_OUTCMP3     = 14;
  localparam int BIT_INCAP3      = 13;
  localparam int BIT_TIMER3      = 12;
  localparam int BIT_EXTPIN2     = 11;
  localparam int BIT_OUTCMP2     = 10;
  localparam int BIT_INCAP2      = 9;
  localparam int BIT_TIMER2      = 8;
  localparam int BIT_EXTPIN1     = 7;
  localparam int BIT_OUTCMP1     = 6;
  localparam int BIT_INCAP1      = 5;
  localparam int BIT_TIMER1      = 4;
  localparam int BIT_EXTPIN0     = 3;
  localparam int BIT_CORE_SOFT1  = 2;
  localparam int BIT_CORE_SOFT0  = 1;
  localparam int BIT_CORE_TICK   = 0;
  localparam int EXTPIN_BIT [NUM_EXTPIN] = '{BIT_EXTPIN0, BIT_EXTPIN1, BIT_EXTPIN2,
                                             BIT_EXTPIN3, BIT_EXTPIN4};

  // ----------------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------------
  typedef enum logic [1:0] {
    OP_STORE = 2'b00,
    OP_CLR   = 2'b01,
    OP_SET   = 2'b10,
    OP_INV   = 2'b11
  } wr_op_e;

  // One-cycle request pulses from on-chip sources, grouped by unit kind.
  typedef struct packed {
    logic       twi1_master;
    logic       twi1_slave;
    logic       twi1_collision;
    logic       uart1_tx;
    logic       uart1_rx;
    logic       uart1_err;
    logic       sync1_rx;
    logic       sync1_tx;
    logic       sync1_err;
    logic [4:0] timer;
    logic [4:0] outcmp;
    logic [4:0] incap;
    logic       core_soft1;
    logic       core_soft0;
    logic       core_tick;
  } source_req_s;

  // ----------------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------------
  function automatic logic [FLAG_W-1:0] strbMask(input logic [STRB_W-1:0] strb);
    logic [FLAG_W-1:0] m;
    m = '0;
    for (int i = 0; i < STRB_W; i++) begin
      m[i*8 +: 8] = {8{strb[i]}};
    end
    return m;
  endfunction

endpackage

// ===== hdl/flag_bank_cells.sv
// Storage cells of the 32 request flags with software update and hardware set.
`timescale 1ns/10ps
module flag_bank_cells
  import flag_bank_pkg::*;
(
  // Clock and reset
  input  wire logic              clk,
  input  wire logic              rst,
  // Software update
  input  wire logic              wrEn,
  input  wire wr_op_e            wrOp,
  input  wire logic [FLAG_W-1:0] wrData,
  input  wire logic [FLAG_W-1:0] wrMask,
  // Hardware requests
  input  wire logic [FLAG_W-1:0] setReq,
  // Flags
  output logic      [FLAG_W-1:0] flags
);

  logic [FLAG_W-1:0] next_flags;
  logic [FLAG_W-1:0] sel;

  always_comb begin
    sel        = wrData & wrMask;
    next_flags = flags;
    if (wrEn) begin
      unique case (wrOp)
        OP_STORE: next_flags = (flags & ~wrMask) | sel;
        OP_CLR:   next_flags = flags & ~sel;
        OP_SET:   next_flags = flags | sel;
        OP_INV:   next_flags = flags ^ sel;
      endcase
    end
    // A request in the same cycle as a clearing write must not be lost.
    next_flags = next_flags | setReq;
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      flags <= FLAG_RESET;
    end else begin
      flags <= next_flags;
    end
  end

endmodule

// ===== hdl/irq_flag_bank0.sv
// AXI4-Lite slave holding interrupt request flag bank 0 and its set sources.
`timescale 1ns/10ps
module irq_flag_bank0
  import flag_bank_pkg::*;
(
  // Clock and reset
  input  wire logic                  clk,
  input  wire logic                  rst,
  // AXI4-Lite write address
  input  wire logic [ADDR_W-1:0]     s_axi_awaddr,
  input  wire logic                  s_axi_awvalid,
  output logic                       s_axi_awready,
  // AXI4-Lite write data
  input  wire logic [FLAG_W-1:0]     s_axi_wdata,
  input  wire logic [STRB_W-1:0]     s_axi_wstrb,
  input  wire logic                  s_axi_wvalid,
  output logic                       s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0]                 s_axi_bresp,
  output logic                       s_axi_bvalid,
  input  wire logic                  s_axi_bready,
  // AXI4-Lite read address
  input  wire logic [ADDR_W-1:0]     s_axi_araddr,
  input  wire logic                  s_axi_arvalid,
  output logic                       s_axi_arready,
  // AXI4-Lite read data
  output logic [FLAG_W-1:0]          s_axi_rdata,
  output logic [1:0]                 s_axi_rresp,
  output logic                       s_axi_rvalid,
  input  wire logic                  s_axi_rready,
  // Request sources
  input  wire source_req_s           srcReq,
  input  wire logic [NUM_EXTPIN-1:0] extPin,
  // Flag state
  output logic [FLAG_W-1:0]          reqFlags
);

  // ----------------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------------
  function automatic logic addrMapped(input logic [ADDR_W-1:0] a);
    return (a == OFF_FLAGS) || (a == OFF_CLR) || (a == OFF_SET) ||
           (a == OFF_INV) || (a == OFF_POL);
  endfunction

  // ----------------------------------------------------------------------
  // Write channel holding
  // ----------------------------------------------------------------------
  logic                  awHeld;
  logic [ADDR_W-1:0]     awAddr;
  logic                  wHeld;
  logic [FLAG_W-1:0]     wData;
  logic [STRB_W-1:0]     wStrb;
  logic                  doWrite;
  logic                  flagWrEn;
  wr_op_e                flagOp;
  logic [NUM_EXTPIN-1:0] edgePol;
  logic [FLAG_W-1:0]     wrMask;

  // Address and data are taken in either order; the write fires when both are held and no write response is pending.
  assign doWrite = awHeld && wHeld && !s_axi_bvalid;

  // The byte mask is a named signal because a bit range cannot be taken of a call.
  assign wrMask = strbMask(wStrb);

  always_ff @(posedge clk) begin
    if (rst) begin
      awHeld        <= 1'b0;
      awAddr        <= '0;
      s_axi_awready <= 1'b0;
    end else if (s_axi_awvalid && s_axi_awready) begin
      awHeld        <= 1'b1;
      awAddr        <= s_axi_awaddr;
      s_axi_awready <= 1'b0;
    end else if (doWrite || !awHeld) begin
      awHeld        <= 1'b0;
      s_axi_awready <= 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      wHeld        <= 1'b0;
      wData        <= '0;
      wStrb        <= '0;
      s_axi_wready <= 1'b0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      wHeld        <= 1'b1;
      wData        <= s_axi_wdata;
      wStrb        <= s_axi_wstrb;
      s_axi_wready <= 1'b0;
    end else if (doWrite || !wHeld) begin
      wHeld        <= 1'b0;
      s_axi_wready <= 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= RESP_OKAY;
    end else if (doWrite) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= addrMapped(awAddr) ? RESP_OKAY : RESP_DECERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // ----------------------------------------------------------------------
  // Register effects
  // ----------------------------------------------------------------------
  always_comb begin
    flagWrEn = doWrite;
    flagOp   = OP_STORE;
    if (awAddr == OFF_FLAGS) begin
      flagOp = OP_STORE;
    end else if (awAddr == OFF_CLR) begin
      flagOp = OP_CLR;
    end else if (awAddr == OFF_SET) begin
      flagOp = OP_SET;
    end else if (awAddr == OFF_INV) begin
      flagOp = OP_INV;
    end else begin
      flagWrEn = 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      edgePol <= POL_RESET;
    end else if (doWrite && awAddr == OFF_POL) begin
      edgePol <= (edgePol & ~wrMask[NUM_EXTPIN-1:0]) |
                 (wData[NUM_EXTPIN-1:0] & wrMask[NUM_EXTPIN-1:0]);
    end
  end

  // ----------------------------------------------------------------------
  // External pin edges
  // ----------------------------------------------------------------------
  logic [NUM_EXTPIN-1:0] pinMeta;
  logic [NUM_EXTPIN-1:0] pinSync;
  logic [NUM_EXTPIN-1:0] pinLast;
  logic [1:0]            settle;
  logic [NUM_EXTPIN-1:0] pinEdge;

  always_ff @(posedge clk) begin
    if (rst) begin
      pinMeta <= '0;
      pinSync <= '0;
      pinLast <= '0;
    end else begin
      pinMeta <= extPin;
      pinSync <= pinMeta;
      pinLast <= pinSync;
    end
  end

  // Edges are ignored until the synchroniser has filled, so a pin that is
  // already high at reset release does not look like a fresh request.
  always_ff @(posedge clk) begin
    if (rst) begin
      settle <= '0;
    end else if (settle != SETTLE_CYCLES) begin
      settle <= settle + 2'h1;
    end
  end

  always_comb begin
    for (int i = 0; i < NUM_EXTPIN; i++) begin
      pinEdge[i] = (settle == SETTLE_CYCLES) &&
                   (edgePol[i] ? (pinSync[i] && !pinLast[i]) : (!pinSync[i] && pinLast[i]));
    end
  end

  // ----------------------------------------------------------------------
  // Request placement
  // ----------------------------------------------------------------------
  logic [FLAG_W-1:0] setReq;

  always_comb begin
    setReq                  = '0;
    setReq[BIT_TWI1_MASTER] = srcReq.twi1_master;
    setReq[BIT_TWI1_SLAVE]  = srcReq.twi1_slave;
    setReq[BIT_TWI1_COLL]   = srcReq.twi1_collision;
    setReq[BIT_UART1_TX]    = srcReq.uart1_tx;
    setReq[BIT_UART1_RX]    = srcReq.uart1_rx;
    setReq[BIT_UART1_ERR]   = srcReq.uart1_err;
    setReq[BIT_SYNC1_RX]    = srcReq.sync1_rx;
    setReq[BIT_SYNC1_TX]    = srcReq.sync1_tx;
    setReq[BIT_SYNC1_ERR]   = srcReq.sync1_err;
    setReq[BIT_OUTCMP5]     = srcReq.outcmp[4];
    setReq[BIT_INCAP5]      = srcReq.incap[4];
    setReq[BIT_TIMER5]      = srcReq.timer[4];
    setReq[BIT_OUTCMP4]     = srcReq.outcmp[3];
    setReq[BIT_INCAP4]      = srcReq.incap[3];
    setReq[BIT_TIMER4]      = srcReq.timer[3];
    setReq[BIT_OUTCMP3]     = srcReq.outcmp[2];
    setReq[BIT_INCAP3]      = srcReq.incap[2];
    setReq[BIT_TIMER3]      = srcReq.timer[2];
    setReq[BIT_OUTCMP2]     = srcReq.outcmp[1];
    setReq[BIT_INCAP2]      = srcReq.incap[1];
    setReq[BIT_TIMER2]      = srcReq.timer[1];
    setReq[BIT_OUTCMP1]     = srcReq.outcmp[0];
    setReq[BIT_INCAP1]      = srcReq.incap[0];
    setReq[BIT_TIMER1]      = srcReq.timer[0];
    setReq[BIT_CORE_SOFT1]  = srcReq.core_soft1;
    setReq[BIT_CORE_SOFT0]  = srcReq.core_soft0;
    setReq[BIT_CORE_TICK]   = srcReq.core_tick;
    // Pins 0, then 1, 2 and 3, then 4 land in their own slots.
    for (int i = 0; i < NUM_EXTPIN; i++) begin
      setReq[EXTPIN_BIT[i]] = pinEdge[i];
    end
  end

  flag_bank_cells cells (
    .clk    (clk),
    .rst    (rst),
    .wrEn   (flagWrEn),
    .wrOp   (flagOp),
    .wrData (wData),
    .wrMask (wrMask),
    .setReq (setReq),
    .flags  (reqFlags)
  );

  // ----------------------------------------------------------------------
  // Read channel
  // ----------------------------------------------------------------------
  logic [FLAG_W-1:0] readValue;

  // Alias registers are write-only strobes and read back as zero.
  always_comb begin
    readValue = '0;
    if (s_axi_araddr == OFF_FLAGS) begin
      readValue = reqFlags;
    end else if (s_axi_araddr == OFF_POL) begin
      readValue[NUM_EXTPIN-1:0] = edgePol;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= '0;
      s_axi_rresp   <= RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b1;
      s_axi_rdata   <= readValue;
      s_axi_rresp   <= addrMapped(s_axi_araddr) ? RESP_OKAY : RESP_DECERR;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid  <= 1'b0;
      s_axi_arready <= 1'b1;
    end else if (!s_axi_rvalid) begin
      s_axi_arready <= 1'b1;
    end
  end

endmodule

// ===== tb/irq_flag_bank0_monitor.sv
// Checker of bus answers and flag behaviour for request flag bank 0.
`timescale 1ns/10ps
module irq_flag_bank0_monitor
  import flag_bank_pkg::*;
(
  // Clock and reset
  input wire logic              clk,
  input wire logic              rst,
  // Bus handshakes
  input wire logic              s_axi_awvalid,
  input wire logic              s_axi_awready,
  input wire logic              s_axi_wvalid,
  input wire logic              s_axi_wready,
  input wire logic [1:0]        s_axi_bresp,
  input wire logic              s_axi_bvalid,
  input wire logic              s_axi_bready,
  input wire logic              s_axi_arvalid,
  input wire logic              s_axi_arready,
  input wire logic [FLAG_W-1:0] s_axi_rdata,
  input wire logic              s_axi_rvalid,
  input wire logic              s_axi_rready,
  // Requests and flags
  input wire source_req_s       srcReq,
  input wire logic [FLAG_W-1:0] reqFlags
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  sequence wrBoth;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready && !s_axi_bvalid;
  endsequence
  sequence arTake;
    s_axi_arvalid && s_axi_arready;
  endsequence

  AST_RESET_CLEAR: assert property (disable iff (1'b0) rst |=> reqFlags == FLAG_RESET)
    else $error("flags not cleared by reset");
  AST_TWI_MASTER_BIT: assert property (srcReq.twi1_master |=> reqFlags[31])
    else $error("two-wire master flag not set");
  AST_UART_ERR_BIT: assert property (srcReq.uart1_err |=> reqFlags[26])
    else $error("uart error flag not set");
  AST_TIMER5_BIT: assert property (srcReq.timer[4] |=> reqFlags[20])
    else $error("timer 5 flag not set");
  // A flag may only drop at the edge where a write completes.
  AST_FLAG_STICKY: assert property (!$past(rst) && |($past(reqFlags) & ~reqFlags)
    |-> $rose(s_axi_bvalid))
    else $error("flag dropped without a write");
  AST_WRITE_ANSWER: assert property (wrBoth |-> ##[1:2] s_axi_bvalid)
    else $error("write not answered");
  AST_READ_ANSWER: assert property (arTake |=> s_axi_rvalid && !s_axi_arready)
    else $error("read not answered");
  AST_READ_HOLD: assert property (s_axi_rvalid && !s_axi_rready
    |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data not held");
  AST_RESP_HOLD: assert property (s_axi_bvalid && !s_axi_bready
    |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response not held");
endmodule

bind irq_flag_bank0 irq_flag_bank0_monitor mon (
  .clk(clk), .rst(rst), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
  .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
  .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid),
  .s_axi_rready(s_axi_rready), .srcReq(srcReq), .reqFlags(reqFlags));

// ===== tb/req_source_model.sv
// Behavioural model of the on-chip sources and pins that raise requests.
`timescale 1ns/10ps
module req_source_model
  import flag_bank_pkg::*;
(
  // Clock
  input wire logic              clk,
  // Requests toward the bank
  output source_req_s           srcReq,
  output logic [NUM_EXTPIN-1:0] extPin
);
  initial begin
    srcReq = '0;
    extPin = '0;
  end
  // A source holds its request for exactly one cycle, so stickiness is the bank's job.
  task automatic pulse(input source_req_s m);
    srcReq <= m;
    @(posedge clk);
    srcReq <= '0;
  endtask
  // Pins are plain levels; the bank finds the edge itself.
  task automatic pin(input int p, input logic v);
    extPin[p] <= v;
  endtask
endmodule

// ===== tb/tb_irq_flag_bank0.sv
// Testbench of request flag bank 0 over its register bus and request inputs.
`timescale 1ns/10ps
module tb_irq_flag_bank0;
  import flag_bank_pkg::*;
  logic                  clk, rst;
  logic [ADDR_W-1:0]     s_axi_awaddr, s_axi_araddr;
  logic [FLAG_W-1:0]     s_axi_wdata, s_axi_rdata, reqFlags;
  logic [STRB_W-1:0]     s_axi_wstrb;
  logic [1:0]            s_axi_bresp, s_axi_rresp;
  logic                  s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic                  s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic                  s_axi_rvalid, s_axi_rready;
  source_req_s           srcReq;
  logic [NUM_EXTPIN-1:0] extPin;
  logic [26:0]           v;
  int                    n_errors, n_tests;
  int bitMap [27] = '{0, 1, 2, 5, 9, 13, 17, 21, 6, 10, 14, 18, 22, 4, 8, 12, 16, 20,
                      23, 24, 25, 26, 27, 28, 29, 30, 31};
  int pinBit [NUM_EXTPIN] = '{3, 7, 11, 15, 19};

  irq_flag_bank0 dut (.clk(clk), .rst(rst), .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .srcReq(srcReq), .extPin(extPin), .reqFlags(reqFlags));
  req_source_model src (.clk(clk), .srcReq(srcReq), .extPin(extPin));

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  // ----------------------------------------------------------------------
  // Bus tasks
  // ----------------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_errors++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // Ready is raised late on purpose so the answer has to stand for a while.
  task automatic wr(input logic [4:0] a, input logic [31:0] d, input logic [3:0] s,
                    input logic [1:0] r);
    logic aDone;
    logic dDone;
    aDone = 1'b0;
    dDone = 1'b0;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= s;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    while (!(aDone && dDone)) begin
      @(posedge clk);
      aDone |= s_axi_awvalid & s_axi_awready;
      dDone |= s_axi_wvalid & s_axi_wready;
      if (aDone) s_axi_awvalid <= 1'b0;
      if (dDone) s_axi_wvalid <= 1'b0;
    end
    repeat (2) @(posedge clk);
    s_axi_bready <= 1'b1;
    do @(posedge clk); while (!s_axi_bvalid);
    s_axi_bready <= 1'b0;
    chk({30'h0, s_axi_bresp}, {30'h0, r});
  endtask
  task automatic rd(input logic [4:0] a, input logic [31:0] d, input logic [1:0] r);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do @(posedge clk); while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    repeat (2) @(posedge clk);
    s_axi_rready <= 1'b1;
    do @(posedge clk); while (!s_axi_rvalid);
    s_axi_rready <= 1'b0;
    chk(s_axi_rdata, d);
    chk({30'h0, s_axi_rresp}, {30'h0, r});
  endtask
  task automatic conclude;
    $display("comparisons %0d mismatches %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  initial begin
    #160000;
    n_errors++;
    conclude;
  end

  initial begin
    n_errors = 0;
    n_tests = 0;
    rst = 1'b1;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = '0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    chk(reqFlags, 32'h0);
    rd(OFF_FLAGS, 32'h0, RESP_OKAY);
    for (int i = 0; i < 27; i++) begin
      v = '0;
      v[i] = 1'b1;
      src.pulse(v);
      repeat (3) @(posedge clk);
      rd(OFF_FLAGS, 32'h1 << bitMap[i], RESP_OKAY);
      wr(OFF_FLAGS, 32'h0, 4'hf, RESP_OKAY);
    end
    wr(OFF_POL, 32'h1f, 4'hf, RESP_OKAY);
    for (int p = 0; p < NUM_EXTPIN; p++) begin
      src.pin(p, 1'b1);
      repeat (6) @(posedge clk);
      rd(OFF_FLAGS, 32'h1 << pinBit[p], RESP_OKAY);
      wr(OFF_FLAGS, 32'h0, 4'hf, RESP_OKAY);
      src.pin(p, 1'b0);
      repeat (6) @(posedge clk);
      rd(OFF_FLAGS, 32'h0, RESP_OKAY);
    end
    rd(OFF_POL, 32'h1f, RESP_OKAY);
    wr(OFF_POL, 32'h0, 4'hf, RESP_OKAY);
    src.pin(0, 1'b1);
    repeat (6) @(posedge clk);
    rd(OFF_FLAGS, 32'h0, RESP_OKAY);
    src.pin(0, 1'b0);
    repeat (6) @(posedge clk);
    rd(OFF_FLAGS, 32'h1 << BIT_EXTPIN0, RESP_OKAY);
    wr(OFF_FLAGS, 32'ha5a50f0f, 4'hf, RESP_OKAY);
    rd(OFF_FLAGS, 32'ha5a50f0f, RESP_OKAY);
    wr(OFF_CLR, 32'h0000000f, 4'hf, RESP_OKAY);
    wr(OFF_SET, 32'h000000f0, 4'hf, RESP_OKAY);
    wr(OFF_INV, 32'hffff0000, 4'hf, RESP_OKAY);
    rd(OFF_FLAGS, 32'h5a5a0ff0, RESP_OKAY);
    wr(OFF_FLAGS, 32'h0, 4'h1, RESP_OKAY);
    rd(OFF_FLAGS, 32'h5a5a0f00, RESP_OKAY);
    rd(OFF_INV, 32'h0, RESP_OKAY);
    wr(5'h14, 32'hffffffff, 4'hf, RESP_DECERR);
    rd(5'h14, 32'h0, RESP_DECERR);
    rd(5'h02, 32'h0, RESP_DECERR);
    rd(OFF_FLAGS, 32'h5a5a0f00, RESP_OKAY);
    chk(reqFlags, 32'h5a5a0f00);
    conclude;
  end
endmodule
